/* src/omc_ctrl.sv */
// Control and status logic of a pluggable optical module, with its serial ID slave.
// Assumes raw pins are asynchronous and the serial logic runs on its own clock.
`timescale 1ns/1ps
`include "omc_defines.svh"

module omc_ctrl
  import omc_pkg::*;
#(
  parameter int unsigned INIT_CYCLES = `OMC_T_INIT_CYC,
  parameter logic [7:0] IDENT_CODE = 8'h03, // Arbitrary value.
  parameter logic [7:0] VENDOR_CODE = 8'h5A // Arbitrary value.
)(
  // System clock and reset.
  input wire logic clk,
  input wire logic rst,
  // Serial interface clock.
  input wire logic serial_clk,
  // Control and monitor pins from host and optics.
  input wire logic tx_disable_pin,
  input wire logic laser_fault_pin,
  input wire logic rx_absent_pin,
  input wire logic cal_external,
  // Diagnostic values.
  input wire logic [15:0] diag_rx_power,
  input wire logic [15:0] diag_tx_power,
  input wire logic [15:0] diag_bias,
  input wire logic [15:0] diag_supply,
  input wire logic [15:0] diag_temp,
  // Laser and status outputs.
  output logic laser_on,
  output logic init_done,
  output logic tx_fault_out,
  output logic tx_fault_oe,
  output logic receive_signal_lost_out,
  output logic receive_signal_lost_oe,
  output logic mod_present_out,
  output logic mod_present_oe,
  // Two-wire serial pins.
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe
);

  localparam logic [`OMC_HOLD_W-1:0] HOLD_MAX = `OMC_HOLD_W'(`OMC_T_RESET_CYC);

  // ---------------------------------------------------------------------------
  // System clock domain
  // ---------------------------------------------------------------------------

  logic [2:0] pin_m_r;
  logic [2:0] pin_s_r;
  logic fault_r;
  logic laser_on_r;
  logic rsl_r;
  logic init_done_r;
  logic [31:0] init_cnt_r;
  logic [`OMC_HOLD_W-1:0] hold_cnt_r;
  logic req_m_r;
  logic req_s_r;
  logic ack_r;
  // Toggled by the serial slave at each start; crosses through req_m_r and req_s_r.
  logic tw_req_r;
  omc_word_t hold_r [`OMC_DIAG_WORDS];
  omc_word_t diag_w [`OMC_DIAG_WORDS];

  wire dis_s = pin_s_r[0];
  wire flt_s = pin_s_r[1];
  wire los_s = pin_s_r[2];
  wire hold_full = (hold_cnt_r == HOLD_MAX);
  wire fault_clr = ~dis_s & hold_full;
  wire fault_nxt = init_done_r & (flt_s | (fault_r & ~fault_clr));
  wire laser_on_nxt = init_done_r & ~dis_s & ~fault_nxt;
  wire snap_req = (req_s_r != ack_r);

  assign diag_w[0] = diag_rx_power;
  assign diag_w[1] = diag_tx_power;
  assign diag_w[2] = diag_bias;
  assign diag_w[3] = diag_supply;
  assign diag_w[4] = diag_temp;

  // Fault and signal-lost outputs release high when the condition is active; presence is always driven low.
  assign laser_on = laser_on_r;
  assign init_done = init_done_r;
  assign tx_fault_out = 1'b0;
  assign tx_fault_oe = ~fault_r;
  assign receive_signal_lost_out = 1'b0;
  assign receive_signal_lost_oe = ~rsl_r;
  assign mod_present_out = 1'b0;
  assign mod_present_oe = 1'b1;

  // Pin synchronisers; shut-off resets to asserted, as the pull-up holds it.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pin_m_r <= 3'h1;
      pin_s_r <= 3'h1;
    end
    else
    begin
      pin_m_r <= {rx_absent_pin, laser_fault_pin, tx_disable_pin};
      pin_s_r <= pin_m_r;
    end
  end

  // Initialization window, fault latch, laser drive and signal-lost output.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      init_cnt_r <= 32'h0;
      init_done_r <= 1'b0;
      hold_cnt_r <= '0;
      fault_r <= 1'b0;
      laser_on_r <= 1'b0;
      rsl_r <= 1'b0;
    end
    else
    begin
      init_cnt_r <= init_done_r ? init_cnt_r : init_cnt_r + 32'h1;
      init_done_r <= init_done_r | (init_cnt_r >= INIT_CYCLES - 1);
      hold_cnt_r <= ~dis_s ? '0 : (hold_full ? hold_cnt_r : hold_cnt_r + 1'b1);
      fault_r <= fault_nxt;
      laser_on_r <= laser_on_nxt;
      rsl_r <= los_s;
    end
  end

  // Diagnostic snapshot on a toggle request from the serial side.
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      req_m_r <= 1'b0;
      req_s_r <= 1'b0;
      ack_r <= 1'b0;
    end
    else
    begin
      req_m_r <= tw_req_r;
      req_s_r <= req_m_r;
      ack_r <= req_s_r;
    end
  end

  // Each diagnostic word is captured while the request is open.
  for (genvar i = 0; i < `OMC_DIAG_WORDS; i++)
  begin : g_hold
    always_ff @(posedge clk)
    begin
      if (rst)
        hold_r[i] <= 16'h0000;
      else if (snap_req)
        hold_r[i] <= diag_w[i];
    end
  end

  // ---------------------------------------------------------------------------
  // Serial clock domain
  // ---------------------------------------------------------------------------

  omc_tw_state_e st_r;
  logic srst_m_r;
  logic srst_r;
  logic [2:0] tw_m_r;
  logic [2:0] tw_s_r;
  logic [1:0] tw_d_r;
  logic ack_m_r;
  logic ack_s_r;
  logic ack_d_r;
  logic [7:0] sh_r;
  logic [3:0] cnt_r;
  logic [7:0] ptr_r;
  logic rw_r;
  logic nack_r;
  logic oe_r;
  omc_word_t snap_r [`OMC_DIAG_WORDS];
  omc_byte_t id_rom [16];

  wire scl_s = tw_s_r[0];
  wire sda_s = tw_s_r[1];
  wire cal_s = tw_s_r[2];
  wire scl_rise = scl_s & ~tw_d_r[0];
  wire scl_fall = ~scl_s & tw_d_r[0];
  wire start_c = scl_s & tw_d_r[1] & ~sda_s;
  wire stop_c = scl_s & ~tw_d_r[1] & sda_s;
  wire [7:0] diag_off = ptr_r - `OMC_DIAG_BASE;
  wire in_id = (ptr_r < `OMC_ID_LEN);
  wire in_diag = (ptr_r >= `OMC_DIAG_BASE) && (diag_off < `OMC_DIAG_LEN);
  wire [15:0] diag_sel = snap_r[diag_off[3:1]];
  wire [7:0] diag_byte = diag_off[0] ? diag_sel[7:0] : diag_sel[15:8];
  wire [7:0] rd_byte = in_id ? id_rom[ptr_r[3:0]] :
                       (in_diag ? diag_byte : `OMC_UNMAPPED_BYTE);
  wire addr_hit = (sh_r[7:1] == `OMC_DEV_ADDR);

  assign sda_out = 1'b0;
  assign sda_oe = oe_r;

  // Identification bytes; one byte reports the calibration mode.
  for (genvar j = 0; j < 16; j++)
  begin : g_id
    if (j == `OMC_ID_IDENT_IDX)
    begin : g_ident
      assign id_rom[j] = IDENT_CODE;
    end
    else if (j == `OMC_ID_VENDOR_IDX)
    begin : g_vendor
      assign id_rom[j] = VENDOR_CODE;
    end
    else if (j == `OMC_ID_DIAG_IDX)
    begin : g_diag
      assign id_rom[j] = 8'(({7'h00, ~cal_s} << `OMC_DIAG_INT_BIT) |
                            ({7'h00, cal_s} << `OMC_DIAG_EXT_BIT));
    end
    else
    begin : g_zero
      assign id_rom[j] = 8'h00;
    end
  end

  // Reset and pin synchronisers for the serial side.
  always_ff @(posedge serial_clk)
  begin
    srst_m_r <= rst;
    srst_r <= srst_m_r;
    tw_m_r <= {cal_external, sda_in, scl_in};
    tw_s_r <= tw_m_r;
    tw_d_r <= tw_s_r[1:0];
    ack_m_r <= ack_r;
    ack_s_r <= ack_m_r;
    ack_d_r <= ack_s_r;
  end

  // Diagnostic copy taken once the snapshot handshake returns.
  for (genvar k = 0; k < `OMC_DIAG_WORDS; k++)
  begin : g_snap
    always_ff @(posedge serial_clk)
    begin
      if (srst_r)
        snap_r[k] <= 16'h0000;
      else if (ack_s_r != ack_d_r)
        snap_r[k] <= hold_r[k];
    end
  end

  // Two-wire slave: address, pointer write, sequential reads.
  always_ff @(posedge serial_clk)
  begin
    if (srst_r)
    begin
      st_r <= TW_IDLE;
      tw_req_r <= 1'b0;
      sh_r <= 8'h00;
      cnt_r <= 4'h0;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      oe_r <= 1'b0;
    end
    else if (stop_c)
    begin
      st_r <= TW_IDLE;
      oe_r <= 1'b0;
    end
    else if (start_c)
    begin
      st_r <= TW_ADDR;
      cnt_r <= 4'h0;
      oe_r <= 1'b0;
      tw_req_r <= ~tw_req_r;
    end
    else
    begin
      case (st_r)
        TW_ADDR, TW_WPTR:
        begin
          if (scl_rise)
          begin
            sh_r <= {sh_r[6:0], sda_s};
            cnt_r <= cnt_r + 4'h1;
          end
          else if (scl_fall && cnt_r == 4'h8)
          begin
            if (st_r == TW_WPTR)
            begin
              ptr_r <= sh_r;
              st_r <= TW_ACKW;
              oe_r <= 1'b1;
            end
            else if (addr_hit)
            begin
              rw_r <= sh_r[0];
              st_r <= TW_ACKA;
              oe_r <= 1'b1;
            end
            else
              st_r <= TW_IDLE;
          end
        end
        TW_ACKA, TW_ACKW:
        begin
          if (scl_fall)
          begin
            cnt_r <= 4'h0;
            if (st_r == TW_ACKA && rw_r)
            begin
              sh_r <= rd_byte;
              oe_r <= ~rd_byte[7];
              st_r <= TW_RDAT;
            end
            else
            begin
              oe_r <= 1'b0;
              st_r <= TW_WPTR;
            end
          end
        end
        TW_RDAT:
        begin
          if (scl_fall)
          begin
            if (cnt_r == 4'h7)
            begin
              oe_r <= 1'b0;
              ptr_r <= ptr_r + 8'h01;
              st_r <= TW_RACK;
            end
            else
            begin
              sh_r <= {sh_r[6:0], 1'b1};
              oe_r <= ~sh_r[6];
              cnt_r <= cnt_r + 4'h1;
            end
          end
        end
        TW_RACK:
        begin
          if (scl_rise)
            nack_r <= sda_s;
          else if (scl_fall)
          begin
            cnt_r <= 4'h0;
            if (nack_r)
              st_r <= TW_IDLE;
            else
            begin
              sh_r <= rd_byte;
              oe_r <= ~rd_byte[7];
              st_r <= TW_RDAT;
            end
          end
        end
        default:
          st_r <= TW_IDLE;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_off;
    dis_s |=> !laser_on_r;
  endproperty
  a_off: assert property (p_off) else $error("Laser stays on while shut off.");

  property p_on;
    $fell(dis_s) && init_done_r && !flt_s && !fault_r |=> laser_on_r;
  endproperty
  a_on: assert property (p_on) else $error("Laser not restored on release.");

  property p_init;
    !init_done_r |=> !fault_r && !laser_on_r;
  endproperty
  a_init: assert property (p_init) else $error("Fault or light during init.");

  property p_fault;
    init_done_r && $rose(laser_fault_pin) |-> ##[2:4] !tx_fault_oe;
  endproperty
  a_fault: assert property (p_fault) else $error("Fault indication late.");

  property p_sticky;
    fault_r && dis_s |=> fault_r;
  endproperty
  a_sticky: assert property (p_sticky) else $error("Fault cleared while shut off.");

  property p_clear;
    hold_full && dis_s ##1 !dis_s && !flt_s && init_done_r |=> !fault_r && laser_on_r;
  endproperty
  a_clear: assert property (p_clear) else $error("Fault not cleared after hold.");

  property p_los;
    $changed(rx_absent_pin) |-> ##[2:3] (receive_signal_lost_oe == !$past(rx_absent_pin, 2));
  endproperty
  a_los: assert property (p_los) else $error("Signal-lost output not following.");

  property p_present;
    mod_present_oe && !mod_present_out && !(laser_on_r && $past(dis_s));
  endproperty
  a_present: assert property (p_present) else $error("Presence or shut-off wrong.");

  property p_ack;
    @(posedge serial_clk) disable iff (srst_r)
      (st_r == TW_ADDR) && scl_fall && cnt_r == 4'h8 && addr_hit |=> oe_r && st_r == TW_ACKA;
  endproperty
  a_ack: assert property (p_ack) else $error("Address not acknowledged.");

  property p_rdbit;
    @(posedge serial_clk) disable iff (srst_r)
      (st_r == TW_RDAT) |-> (oe_r == !sh_r[7]);
  endproperty
  a_rdbit: assert property (p_rdbit) else $error("Read bit mismatch.");

  c_read: cover property (@(posedge serial_clk) disable iff (srst_r)
    st_r == TW_RACK ##1 st_r == TW_RDAT);
  c_clear: cover property (fault_r ##1 !fault_r);
  c_los: cover property ($rose(rsl_r));
  c_diag: cover property (@(posedge serial_clk) disable iff (srst_r) in_diag && st_r == TW_RDAT);

endmodule

/* src/omc_defines.svh */
// Constants for the optical module control and status block.
// Assumes a 125 MHz system clock and a separate serial-interface clock.
//
// Summary of operation
// - Laser light returns within 1 ms after shut-off input is released.
// - Laser light goes out within 10 us after shut-off input is raised.
// - Initialization completes within 300 ms and clears any latched laser fault.
// - A laser fault after initialization raises the fault indication within 100 us.
// - Signal-lost output follows received-signal absence within 100 us.
// - Fault output low in normal operation, high when any laser fault exists after initialization.
// - Shut-off input high turns light off; undriven input reads high.
// - Presence line is tied to ground while the module is inserted.
// - Serial traffic uses one line as clock and one as data; host clocks.
// - Serial reads return identification bytes and live diagnostic values.
// - Diagnostics cover rx power, tx power, bias, supply, temperature, calibration mode.
`ifndef OMC_DEFINES_SVH
`define OMC_DEFINES_SVH

// -----------------------------------------------------------------------------
// Timing
// -----------------------------------------------------------------------------
`define OMC_CLK_PERIOD_NS 8
`define OMC_T_RESET_US 10
`define OMC_T_INIT_MS 300
`define OMC_F_SERIAL_KHZ 400
`define OMC_T_RESET_CYC ((`OMC_T_RESET_US * 1000 + `OMC_CLK_PERIOD_NS - 1) / `OMC_CLK_PERIOD_NS)
`define OMC_T_INIT_CYC (`OMC_T_INIT_MS * 1000000 / `OMC_CLK_PERIOD_NS)
`define OMC_HOLD_W 11

// -----------------------------------------------------------------------------
// Serial memory map
// -----------------------------------------------------------------------------
`define OMC_DEV_ADDR 7'h50
`define OMC_ID_LEN 8'h10
`define OMC_ID_IDENT_IDX 0
`define OMC_ID_VENDOR_IDX 1
`define OMC_ID_DIAG_IDX 2
`define OMC_DIAG_BASE 8'h60
`define OMC_DIAG_LEN 8'h0A
`define OMC_DIAG_WORDS 5
`define OMC_UNMAPPED_BYTE 8'hFF
`define OMC_DIAG_INT_BIT 5
`define OMC_DIAG_EXT_BIT 4

`endif

/* src/omc_pkg.sv */
// Types shared by the optical module control and status block.
// Assumes nothing beyond a SystemVerilog compiler.
package omc_pkg;

  typedef logic [7:0] omc_byte_t;
  typedef logic [15:0] omc_word_t;

  // Serial slave states, one-hot.
  typedef enum logic [6:0] {
    TW_IDLE = 7'h01,
    TW_ADDR = 7'h02,
    TW_ACKA = 7'h04,
    TW_WPTR = 7'h08,
    TW_ACKW = 7'h10,
    TW_RDAT = 7'h20,
    TW_RACK = 7'h40
  } omc_tw_state_e;

endpackage

/* verification/omc_host_model.sv */
// Host-side two-wire master model that reads the module's serial memory.
// Assumes the bench resolves the data wire with a pull-up from both enables.
`timescale 1ns/1ps

module omc_host_model #(
  parameter int QTR_NS = 625
)(
  // Two-wire lines.
  output logic scl,
  output logic sda_low,
  input wire logic sda_line
);
  // Bytes read back by the last transfer and the address acknowledge.
  logic [7:0] rbuf [16];
  logic ack;

  // Both lines idle high at time zero.
  initial
  begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // -------------------------------------------------------------------------
  // Bit level
  // -------------------------------------------------------------------------
  // One bit spans four quarters, so the clock never exceeds 400 kHz.
  task automatic bit_io(input logic b, output logic r);
    sda_low = ~b;
    #(QTR_NS) scl = 1'b1;
    #(QTR_NS) r = sda_line;
    #(QTR_NS) scl = 1'b0;
    #(QTR_NS);
  endtask

  // A start also serves as repeated start, since the clock is low on entry.
  task automatic start_c;
    sda_low = 1'b0;
    #(QTR_NS) scl = 1'b1;
    #(QTR_NS) sda_low = 1'b1;
    #(QTR_NS) scl = 1'b0;
    #(QTR_NS);
  endtask

  // Data rises while the clock is high to end the transfer.
  task automatic stop_c;
    sda_low = 1'b1;
    #(QTR_NS) scl = 1'b1;
    #(QTR_NS) sda_low = 1'b0;
    #(QTR_NS);
  endtask

  // -------------------------------------------------------------------------
  // Byte level
  // -------------------------------------------------------------------------
  // Sends a byte most significant bit first and returns the acknowledge.
  task automatic byte_w(input logic [7:0] b, output logic a);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, r);
    a = ~r;
  endtask

  // Reads a byte; the host acknowledges all but the last one.
  task automatic byte_r(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
    begin
      bit_io(1'b1, r);
      d[i] = r;
    end
    bit_io(last, r);
  endtask

  // Sets the pointer, then reads n bytes after a repeated start.
  task automatic rd(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    logic a;
    start_c();
    byte_w({dev, 1'b0}, ack);
    if (ack)
    begin
      byte_w(ptr, a);
      start_c();
      byte_w({dev, 1'b1}, a);
      for (int k = 0; k < n; k++)
        byte_r(k == n - 1, rbuf[k]);
    end
    stop_c();
  endtask
endmodule

/* verification/optical_module_ctrl_status_tb_top.sv */
// Self-checking bench for the optical module control and status block.
// Assumes the host model drives the serial port and the bench drives the pins.
`timescale 1ns/1ps
`include "omc_defines.svh"

module optical_module_ctrl_status_tb_top;
  import omc_pkg::*;
  localparam int INIT_N = 20;
  localparam int CEIL = 98000;
  localparam logic [7:0] ID_C = 8'h03; // Arbitrary value.
  localparam logic [7:0] VEN_C = 8'hC6; // Arbitrary value.

  // -------------------------------------------------------------------------
  // Stimulus, wires and clocks
  // -------------------------------------------------------------------------
  logic clk = 1'b0;
  logic serial_clk = 1'b0;
  logic rst = 1'b1;
  logic tx_en = 1'b0;
  logic tx_val = 1'b0;
  logic fault_pin = 1'b0;
  logic rx_absent = 1'b0;
  logic cal_ext = 1'b0;
  logic [15:0] dg [5] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
  logic laser_on, init_done, fault_oe, los_oe, mp_out, mp_oe, sda_oe, scl, host_low;
  logic fault_out, los_out, sda_o;
  logic [7:0] eq [$];
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  // An undriven shut-off input reads high through the module's pull-up.
  wire tx_dis = tx_en ? tx_val : 1'b1;
  // Open-drain data wire: pulled up unless either side drives a low level.
  wire sda_line = ~(host_low | (sda_oe & ~sda_o));

  always #4 clk = ~clk;
  initial #3 forever #16 serial_clk = ~serial_clk;

  omc_ctrl #(.INIT_CYCLES(INIT_N), .IDENT_CODE(ID_C), .VENDOR_CODE(VEN_C)) DUT (
    .clk(clk), .rst(rst), .serial_clk(serial_clk),
    .tx_disable_pin(tx_dis), .laser_fault_pin(fault_pin), .rx_absent_pin(rx_absent),
    .cal_external(cal_ext), .diag_rx_power(dg[0]), .diag_tx_power(dg[1]),
    .diag_bias(dg[2]), .diag_supply(dg[3]), .diag_temp(dg[4]),
    .laser_on(laser_on), .init_done(init_done), .tx_fault_out(fault_out),
    .tx_fault_oe(fault_oe),
    .receive_signal_lost_out(los_out), .receive_signal_lost_oe(los_oe),
    .mod_present_out(mp_out), .mod_present_oe(mp_oe),
    .scl_in(scl), .sda_in(sda_line), .sda_out(sda_o), .sda_oe(sda_oe)
  );

  omc_host_model u_host (.scl(scl), .sda_low(host_low), .sda_line(sda_line));

  // -------------------------------------------------------------------------
  // Tasks
  // -------------------------------------------------------------------------
  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    checks_done++;
    if (got !== exp)
    begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Reads as many bytes as the expected queue holds and compares them.
  task automatic rd_chk(input logic [6:0] dev, input logic [7:0] ptr, input logic exp_ack);
    u_host.rd(dev, ptr, eq.size());
    chk(16'(u_host.ack), 16'(exp_ack), "address ack");
    if (exp_ack)
      foreach (eq[k])
        chk(16'(u_host.rbuf[k]), 16'(eq[k]), "read byte");
  endtask

  task automatic end_sim;
    if (mismatches == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // A hang counts as a mismatch and closes the run.
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == CEIL)
    begin
      mismatches++;
      end_sim();
    end
  end

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  // Reset spans four serial clocks so the serial side sees it too.
  initial
  begin
    settle(15);
    chk({12'h000, laser_on, init_done, ~fault_oe, ~los_oe}, 16'h0000, "reset state");
    chk({14'h0000, mp_oe, mp_out}, 16'h0002, "presence grounded");
    chk({13'h0000, fault_out, los_out, sda_o}, 16'h0000, "open-drain low levels");
    rst = 1'b0;
    fault_pin = 1'b1;
    settle(INIT_N - 6);
    fault_pin = 1'b0;
    settle(3);
    chk({13'h0000, laser_on, ~fault_oe, init_done}, 16'h0000, "init window");
    settle(6);
    chk({14'h0000, laser_on, init_done}, 16'h0001, "init over, undriven");
    tx_en = 1'b1;
    settle(3);
    chk(16'(laser_on), 16'h0001, "light on");
    tx_val = 1'b1;
    settle(3);
    chk(16'(laser_on), 16'h0000, "light off");
    tx_val = 1'b0;
    settle(3);
    fault_pin = 1'b1;
    settle(3);
    chk({14'h0000, ~fault_oe, laser_on}, 16'h0002, "fault raised");
    fault_pin = 1'b0;
    tx_val = 1'b1;
    settle(1200);
    tx_val = 1'b0;
    settle(4);
    chk({14'h0000, ~fault_oe, laser_on}, 16'h0002, "short hold keeps fault");
    tx_val = 1'b1;
    settle(1260);
    tx_val = 1'b0;
    settle(4);
    chk({14'h0000, ~fault_oe, laser_on}, 16'h0001, "fault cleared");
    rx_absent = 1'b1;
    settle(3);
    chk({15'h0000, ~los_oe}, 16'h0001, "signal lost");
    rx_absent = 1'b0;
    settle(3);
    chk({15'h0000, ~los_oe}, 16'h0000, "signal back");
    dg = '{16'h1A2B, 16'h3C4D, 16'h5E6F, 16'h7081, 16'h92A3};
    eq = {ID_C, VEN_C, 8'h20};
    rd_chk(`OMC_DEV_ADDR, 8'h00, 1'b1);
    eq = {};
    for (int i = 0; i < 5; i++)
      eq = {eq, dg[i][15:8], dg[i][7:0]};
    rd_chk(`OMC_DEV_ADDR, `OMC_DIAG_BASE, 1'b1);
    cal_ext = 1'b1;
    eq = {8'h10};
    rd_chk(`OMC_DEV_ADDR, 8'h02, 1'b1);
    eq = {8'h00, `OMC_UNMAPPED_BYTE};
    rd_chk(`OMC_DEV_ADDR, 8'h0F, 1'b1);
    eq = {8'h00};
    rd_chk(7'h51, 8'h00, 1'b0);
    end_sim();
  end
endmodule
